// File: hw/pmsa_regs.sv
// PHY status low bits, identifier pair and auto-negotiation advertisement register bank
`timescale 1ns/10ps
`include "pmsa_consts.svh"

module pmsa_regs #(
  parameter logic [21:0] ORG_ID_BITS  = 22'h0A5A5A, // Arbitrary, org bits 3..24 msb first
  parameter logic [5:0]  MODEL_NUMBER = 6'h15,      // Arbitrary
  parameter logic [3:0]  REV_NUMBER   = 4'h3,       // Arbitrary
  parameter logic        EXT_REGS     = 1'b1
) (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire pmsa_pkg::pmsa_addr_t mgmt_addr,
  input  wire logic               mgmt_rd_en,
  input  wire logic               mgmt_wr_en,
  input  wire pmsa_pkg::pmsa_word_t mgmt_wdata,
  output pmsa_pkg::pmsa_word_t    mgmt_rdata,
  output logic                    mgmt_rd_valid,
  input  wire logic               link_live,
  input  wire logic               jabber_live,
  input  wire logic               converter_mode,
  input  wire logic               gigabit_adv,
  output logic                    link_up_latched,
  output logic                    jabber_seen,
  output pmsa_pkg::pmsa_word_t    adv_code_word
);

  // ****************************************
  // Address decode
  // ****************************************
  pmsa_pkg::pmsa_reg_sel_t reg_sel;
  logic                    extended_regs_present;
  logic                    next_page_flag;
  logic                    remote_fault_adv;
  pmsa_pkg::pmsa_taf_t     technology_ability_bits;
  pmsa_pkg::pmsa_sel_t     selector_code;
  pmsa_pkg::pmsa_taf_t     taf_effective;
  logic                    np_effective;
  pmsa_pkg::pmsa_sel_t     sel_transmit;
  pmsa_pkg::pmsa_word_t    stat_word;
  pmsa_pkg::pmsa_word_t    ident_high;
  pmsa_pkg::pmsa_word_t    ident_low;
  pmsa_pkg::pmsa_word_t    adv_word;
  pmsa_pkg::pmsa_word_t    next_rdata;
  logic                    stat_read;
  logic                    adv_write;

  // A literal cannot be bit-selected, so the reset word is named once here
  localparam pmsa_pkg::pmsa_word_t ADV_RESET_WORD = `PMSA_ADV_RESET;

  always_comb begin
    case (mgmt_addr)
      `PMSA_OFF_STATUS:     reg_sel = pmsa_pkg::PMSA_REG_STAT;
      `PMSA_OFF_IDENT_HIGH: reg_sel = pmsa_pkg::PMSA_REG_IDH;
      `PMSA_OFF_IDENT_LOW:  reg_sel = pmsa_pkg::PMSA_REG_IDL;
      `PMSA_OFF_ADVERTISE:  reg_sel = pmsa_pkg::PMSA_REG_ADV;
      default:              reg_sel = pmsa_pkg::PMSA_REG_NONE;
    endcase
  end

  assign stat_read = mgmt_rd_en && (reg_sel == pmsa_pkg::PMSA_REG_STAT);
  // Status offset deliberately has no write decode
  assign adv_write = mgmt_wr_en && (reg_sel == pmsa_pkg::PMSA_REG_ADV);

  // ****************************************
  // Latched status flags
  // ****************************************
  // The read returns the latched value; the refresh lands after it so a
  // link drop between polls is never missed by software.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      link_up_latched <= 1'b0;
    end else if (stat_read) begin
      link_up_latched <= link_live;
    end else begin
      link_up_latched <= link_up_latched & link_live;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      jabber_seen <= 1'b0;
    end else if (stat_read) begin
      jabber_seen <= jabber_live;
    end else begin
      jabber_seen <= jabber_seen | jabber_live;
    end
  end

  assign extended_regs_present = EXT_REGS;

  always_comb begin
    stat_word = 16'h0000;
    stat_word[`PMSA_ST_LINK_BIT]   = link_up_latched;
    stat_word[`PMSA_ST_JABBER_BIT] = jabber_seen;
    stat_word[`PMSA_ST_EXT_BIT]    = extended_regs_present;
  end

  // ****************************************
  // Identifier pair
  // ****************************************
  assign ident_high = ORG_ID_BITS[21:6];
  assign ident_low  = {ORG_ID_BITS[5:0], MODEL_NUMBER, REV_NUMBER};

  // ****************************************
  // Advertisement register
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      next_page_flag <= ADV_RESET_WORD[`PMSA_ADV_NP_BIT];
    end else if (adv_write) begin
      next_page_flag <= mgmt_wdata[`PMSA_ADV_NP_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      remote_fault_adv <= ADV_RESET_WORD[`PMSA_ADV_RF_BIT];
    end else if (adv_write) begin
      remote_fault_adv <= mgmt_wdata[`PMSA_ADV_RF_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      technology_ability_bits <= ADV_RESET_WORD[`PMSA_ADV_TAF_MSB:`PMSA_ADV_TAF_LSB];
    end else if (adv_write) begin
      technology_ability_bits <= mgmt_wdata[`PMSA_ADV_TAF_MSB:`PMSA_ADV_TAF_LSB];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      selector_code <= ADV_RESET_WORD[`PMSA_ADV_SEL_MSB:`PMSA_ADV_SEL_LSB];
    end else if (adv_write) begin
      selector_code <= mgmt_wdata[`PMSA_ADV_SEL_MSB:`PMSA_ADV_SEL_LSB];
    end
  end

  // Stored value survives converter mode, so leaving it restores the old field
  assign taf_effective = converter_mode ? `PMSA_TAF_CONVERTER : technology_ability_bits;
  assign np_effective  = next_page_flag | gigabit_adv;
  // A reserved selector reads back as written but goes out as Ethernet
  assign sel_transmit  = (selector_code == `PMSA_SEL_ETHERNET) ?
                         selector_code : `PMSA_SEL_ETHERNET;

  always_comb begin
    adv_word = 16'h0000;
    adv_word[`PMSA_ADV_NP_BIT] = np_effective;
    adv_word[`PMSA_ADV_RF_BIT] = remote_fault_adv;
    adv_word[`PMSA_ADV_TAF_MSB:`PMSA_ADV_TAF_LSB] = taf_effective;
    adv_word[`PMSA_ADV_SEL_MSB:`PMSA_ADV_SEL_LSB] = selector_code;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      adv_code_word <= `PMSA_ADV_RESET;
    end else begin
      adv_code_word <= {adv_word[15:5], sel_transmit};
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    case (reg_sel)
      pmsa_pkg::PMSA_REG_STAT: next_rdata = stat_word;
      pmsa_pkg::PMSA_REG_IDH:  next_rdata = ident_high;
      pmsa_pkg::PMSA_REG_IDL:  next_rdata = ident_low;
      pmsa_pkg::PMSA_REG_ADV:  next_rdata = adv_word;
      default:                 next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mgmt_rdata <= 16'h0000;
    end else if (mgmt_rd_en) begin
      mgmt_rdata <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mgmt_rd_valid <= 1'b0;
    end else begin
      mgmt_rd_valid <= mgmt_rd_en;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_link_latch_low;
    @(posedge ref_clk) disable iff (rst)
      (!link_live && !stat_read) |=> !link_up_latched;
  endproperty
  a_link_latch_low: assert property (p_link_latch_low)
    else $error("link flag not latched low");

  property p_jabber_hold;
    @(posedge ref_clk) disable iff (rst)
      (jabber_seen && !stat_read) |=> jabber_seen;
  endproperty
  a_jabber_hold: assert property (p_jabber_hold)
    else $error("jabber flag lost before read");

  property p_jabber_set;
    @(posedge ref_clk) disable iff (rst)
      jabber_live |=> jabber_seen;
  endproperty
  a_jabber_set: assert property (p_jabber_set)
    else $error("jabber not flagged");

  property p_ext_read;
    @(posedge ref_clk) disable iff (rst)
      stat_read |=> mgmt_rd_valid && (mgmt_rdata[`PMSA_ST_EXT_BIT] == EXT_REGS)
                    && (mgmt_rdata[15:3] == 13'h0000);
  endproperty
  a_ext_read: assert property (p_ext_read)
    else $error("status read wrong");

  property p_ident_high;
    @(posedge ref_clk) disable iff (rst)
      (mgmt_rd_en && mgmt_addr == `PMSA_OFF_IDENT_HIGH)
        |=> mgmt_rdata == ORG_ID_BITS[21:6];
  endproperty
  a_ident_high: assert property (p_ident_high)
    else $error("identifier high wrong");

  property p_ident_low;
    @(posedge ref_clk) disable iff (rst)
      (mgmt_rd_en && mgmt_addr == `PMSA_OFF_IDENT_LOW)
        |=> mgmt_rdata == {ORG_ID_BITS[5:0], MODEL_NUMBER, REV_NUMBER};
  endproperty
  a_ident_low: assert property (p_ident_low)
    else $error("identifier low wrong");

  property p_adv_reset;
    @(posedge ref_clk)
      rst |=> (adv_code_word == `PMSA_ADV_RESET) && !link_up_latched;
  endproperty
  a_adv_reset: assert property (p_adv_reset)
    else $error("advertisement reset value wrong");

  property p_np_forced;
    @(posedge ref_clk) disable iff (rst)
      gigabit_adv |=> adv_code_word[`PMSA_ADV_NP_BIT];
  endproperty
  a_np_forced: assert property (p_np_forced)
    else $error("next page not forced");

  property p_res_zero;
    @(posedge ref_clk) disable iff (rst)
      (mgmt_rd_en && mgmt_addr == `PMSA_OFF_ADVERTISE)
        |=> !mgmt_rdata[`PMSA_ADV_RES_BIT];
  endproperty
  a_res_zero: assert property (p_res_zero)
    else $error("reserved bit reads one");

  property p_rf_write;
    @(posedge ref_clk) disable iff (rst)
      adv_write ##1 !adv_write
        |=> adv_code_word[`PMSA_ADV_RF_BIT] == $past(mgmt_wdata[`PMSA_ADV_RF_BIT], 2);
  endproperty
  a_rf_write: assert property (p_rf_write)
    else $error("remote fault not sent");

  property p_taf_write;
    @(posedge ref_clk) disable iff (rst)
      (adv_write && !converter_mode) ##1 (!adv_write && !converter_mode)
        |=> adv_code_word[12:5] == $past(mgmt_wdata[12:5], 2);
  endproperty
  a_taf_write: assert property (p_taf_write)
    else $error("ability field not taken");

  property p_converter;
    @(posedge ref_clk) disable iff (rst)
      converter_mode |=> adv_code_word[12:5] == `PMSA_TAF_CONVERTER;
  endproperty
  a_converter: assert property (p_converter)
    else $error("converter field not forced");

  property p_sel_readback;
    @(posedge ref_clk) disable iff (rst)
      adv_write ##1 (mgmt_rd_en && !adv_write && mgmt_addr == `PMSA_OFF_ADVERTISE)
        |=> mgmt_rdata[4:0] == $past(mgmt_wdata[4:0], 2);
  endproperty
  a_sel_readback: assert property (p_sel_readback)
    else $error("selector not stored");

  property p_sel_never_reserved;
    @(posedge ref_clk) disable iff (rst)
      1'b1 |-> adv_code_word[4:0] == `PMSA_SEL_ETHERNET;
  endproperty
  a_sel_never_reserved: assert property (p_sel_never_reserved)
    else $error("reserved selector transmitted");

  property p_stat_write_ignored;
    @(posedge ref_clk) disable iff (rst)
      (mgmt_wr_en && mgmt_addr == `PMSA_OFF_STATUS && !stat_read && jabber_seen)
        |=> jabber_seen;
  endproperty
  a_stat_write_ignored: assert property (p_stat_write_ignored)
    else $error("status write changed state");

  property p_read_refresh;
    @(posedge ref_clk) disable iff (rst)
      stat_read |=> (link_up_latched == $past(link_live))
                    && (jabber_seen == $past(jabber_live));
  endproperty
  a_read_refresh: assert property (p_read_refresh)
    else $error("latched flag not refreshed by read");

endmodule

// File: hw/pmsa_consts.svh
// Offsets, field positions and reset values of the PHY status, identifier and advertisement bank
`ifndef PMSA_CONSTS_SVH
`define PMSA_CONSTS_SVH

// ****************************************
// Management register offsets
// ****************************************
`define PMSA_OFF_STATUS      5'h01
`define PMSA_OFF_IDENT_HIGH  5'h02
`define PMSA_OFF_IDENT_LOW   5'h03
`define PMSA_OFF_ADVERTISE   5'h04

// ****************************************
// Status register field positions
// ****************************************
`define PMSA_ST_EXT_BIT      0
`define PMSA_ST_JABBER_BIT   1
`define PMSA_ST_LINK_BIT     2

// ****************************************
// Identifier field positions
// ****************************************
`define PMSA_IDL_ORG_MSB     15
`define PMSA_IDL_ORG_LSB     10
`define PMSA_IDL_MODEL_MSB   9
`define PMSA_IDL_MODEL_LSB   4
`define PMSA_IDL_REV_MSB     3
`define PMSA_IDL_REV_LSB     0

// ****************************************
// Advertisement field positions and values
// ****************************************
`define PMSA_ADV_NP_BIT      15
`define PMSA_ADV_RES_BIT     14
`define PMSA_ADV_RF_BIT      13
`define PMSA_ADV_TAF_MSB     12
`define PMSA_ADV_TAF_LSB     5
`define PMSA_ADV_SEL_MSB     4
`define PMSA_ADV_SEL_LSB     0
`define PMSA_ADV_RESET       16'h01E1
`define PMSA_TAF_TEN_HALF    8'h01
`define PMSA_TAF_HUND_FULL   8'h08
`define PMSA_TAF_HUND_FOUR   8'h10
`define PMSA_TAF_SYM_PAUSE   8'h20
`define PMSA_TAF_CONVERTER   8'h60
`define PMSA_SEL_ETHERNET    5'h01

`endif

// File: hw/pmsa_pkg.sv
// Types shared by the PHY status, identifier and advertisement bank
package pmsa_pkg;

  typedef logic [15:0] pmsa_word_t;
  typedef logic [4:0]  pmsa_addr_t;
  typedef logic [7:0]  pmsa_taf_t;
  typedef logic [4:0]  pmsa_sel_t;

  // One-hot decode of the addressed register
  typedef enum logic [4:0] {
    PMSA_REG_NONE  = 5'h01,
    PMSA_REG_STAT  = 5'h02,
    PMSA_REG_IDH   = 5'h04,
    PMSA_REG_IDL   = 5'h08,
    PMSA_REG_ADV   = 5'h10
  } pmsa_reg_sel_t;

endpackage

// File: dv/pmsa_mgmt_station.sv
// Management station model that issues register reads and writes to the bank
`timescale 1ns/10ps

module pmsa_mgmt_station (
  input  wire logic                 ref_clk,
  output pmsa_pkg::pmsa_addr_t      mgmt_addr,
  output logic                      mgmt_rd_en,
  output logic                      mgmt_wr_en,
  output pmsa_pkg::pmsa_word_t      mgmt_wdata,
  input  wire pmsa_pkg::pmsa_word_t mgmt_rdata,
  input  wire logic                 mgmt_rd_valid
);
  initial begin
    mgmt_addr  = 5'h00;
    mgmt_rd_en = 1'b0;
    mgmt_wr_en = 1'b0;
    mgmt_wdata = 16'h0000;
  end

  // ****************************************
  // Register access
  // ****************************************
  // Raw mode exists only to break the reserved-bit convention on purpose
  task automatic wr_reg(input pmsa_pkg::pmsa_addr_t addr, input pmsa_pkg::pmsa_word_t data,
                        input logic raw);
    @(negedge ref_clk);
    mgmt_addr  = addr;
    mgmt_wdata = raw ? data : (data & 16'hBFFF);
    mgmt_wr_en = 1'b1;
    @(negedge ref_clk);
    mgmt_wr_en = 1'b0;
    // Released data must not keep looking like the last word
    mgmt_wdata = ~mgmt_wdata;
  endtask

  // Unknown comes back when no answer arrives, so any compare on it fails
  task automatic rd_reg(input pmsa_pkg::pmsa_addr_t addr, output pmsa_pkg::pmsa_word_t data);
    int i;
    @(negedge ref_clk);
    mgmt_addr  = addr;
    mgmt_rd_en = 1'b1;
    @(negedge ref_clk);
    mgmt_rd_en = 1'b0;
    data = 16'hXXXX;
    for (i = 0; i < 4; i++) begin
      if (mgmt_rd_valid === 1'b1) begin
        data = mgmt_rdata;
        break;
      end
      @(negedge ref_clk);
    end
  endtask

  // Read issued in the cycle right after the write, to catch stale read data
  task automatic wr_rd_reg(input pmsa_pkg::pmsa_addr_t addr, input pmsa_pkg::pmsa_word_t wdata,
                           output pmsa_pkg::pmsa_word_t data);
    @(negedge ref_clk);
    mgmt_addr  = addr;
    mgmt_wdata = wdata & 16'hBFFF;
    mgmt_wr_en = 1'b1;
    @(negedge ref_clk);
    mgmt_wr_en = 1'b0;
    mgmt_rd_en = 1'b1;
    mgmt_wdata = ~mgmt_wdata;
    @(negedge ref_clk);
    mgmt_rd_en = 1'b0;
    data = (mgmt_rd_valid === 1'b1) ? mgmt_rdata : 16'hXXXX;
  endtask
endmodule

// File: dv/phy_mgmt_status_id_an_adv_test.sv
// Self-checking testbench for the PHY status, identifier and advertisement bank
`timescale 1ns/10ps
`include "pmsa_consts.svh"
`define PMSA_CHK(nm, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
    end \
  end

module phy_mgmt_status_id_an_adv_test;
  localparam logic [21:0] ORG_ID     = 22'h2C3D1E; // Arbitrary
  localparam logic [5:0]  MODEL      = 6'h2A;      // Arbitrary
  localparam logic [3:0]  REV        = 4'h9;       // Arbitrary
  localparam int          MAX_CYCLES = 4000;

  logic                 ref_clk;
  logic                 rst;
  pmsa_pkg::pmsa_addr_t mgmt_addr;
  logic                 mgmt_rd_en;
  logic                 mgmt_wr_en;
  pmsa_pkg::pmsa_word_t mgmt_wdata;
  pmsa_pkg::pmsa_word_t mgmt_rdata;
  logic                 mgmt_rd_valid;
  logic                 link_live;
  logic                 jabber_live;
  logic                 converter_mode;
  logic                 gigabit_adv;
  logic                 link_up_latched;
  logic                 jabber_seen;
  pmsa_pkg::pmsa_word_t adv_code_word;
  pmsa_pkg::pmsa_word_t rd;
  pmsa_pkg::pmsa_word_t w;
  pmsa_pkg::pmsa_taf_t  taf_list [4];
  int                   n_fail;
  int                   tests_run;
  int                   cycles;

  pmsa_regs #(.ORG_ID_BITS(ORG_ID), .MODEL_NUMBER(MODEL), .REV_NUMBER(REV), .EXT_REGS(1'b1))
  i_dut (
    .ref_clk(ref_clk), .rst(rst), .mgmt_addr(mgmt_addr), .mgmt_rd_en(mgmt_rd_en),
    .mgmt_wr_en(mgmt_wr_en), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mgmt_rd_valid(mgmt_rd_valid), .link_live(link_live), .jabber_live(jabber_live),
    .converter_mode(converter_mode), .gigabit_adv(gigabit_adv),
    .link_up_latched(link_up_latched), .jabber_seen(jabber_seen), .adv_code_word(adv_code_word)
  );

  pmsa_mgmt_station i_mac (
    .ref_clk(ref_clk), .mgmt_addr(mgmt_addr), .mgmt_rd_en(mgmt_rd_en), .mgmt_wr_en(mgmt_wr_en),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rd_valid(mgmt_rd_valid)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Verdict and hang guard
  // ****************************************
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == MAX_CYCLES) begin
      n_fail++;
      summarize();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    taf_list = '{`PMSA_TAF_TEN_HALF, `PMSA_TAF_HUND_FULL, `PMSA_TAF_HUND_FOUR, `PMSA_TAF_SYM_PAUSE};
    rst = 1'b1;
    link_live = 1'b1;
    jabber_live = 1'b0;
    converter_mode = 1'b0;
    gigabit_adv = 1'b0;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    `PMSA_CHK("link flag reset", 1'b0, link_up_latched)
    `PMSA_CHK("code word reset", `PMSA_ADV_RESET, adv_code_word)
    i_mac.rd_reg(`PMSA_OFF_ADVERTISE, rd);
    `PMSA_CHK("adv reset", `PMSA_ADV_RESET, rd)
    // Latched link flag resets low, so the first read still reports it down
    i_mac.rd_reg(`PMSA_OFF_STATUS, rd);
    `PMSA_CHK("status first", 3'b001, rd[2:0])
    i_mac.rd_reg(`PMSA_OFF_STATUS, rd);
    `PMSA_CHK("status second", 3'b101, rd[2:0])
    i_mac.rd_reg(`PMSA_OFF_IDENT_HIGH, rd);
    `PMSA_CHK("id high", ORG_ID[21:6], rd)
    i_mac.rd_reg(`PMSA_OFF_IDENT_LOW, rd);
    `PMSA_CHK("id low org", ORG_ID[5:0], rd[15:10])
    `PMSA_CHK("id model", MODEL, rd[9:4])
    `PMSA_CHK("id revision", REV, rd[3:0])
    i_mac.wr_reg(`PMSA_OFF_IDENT_HIGH, 16'h0000, 1'b0);
    i_mac.wr_reg(`PMSA_OFF_STATUS, 16'h0000, 1'b0);
    i_mac.rd_reg(`PMSA_OFF_IDENT_HIGH, rd);
    `PMSA_CHK("id after write", ORG_ID[21:6], rd)
    i_mac.rd_reg(`PMSA_OFF_STATUS, rd);
    `PMSA_CHK("status after write", 3'b101, rd[2:0])
    i_mac.rd_reg(5'h1F, rd);
    `PMSA_CHK("unmapped read", 16'h0000, rd)
    // One-cycle link drop must survive until software reads it
    @(negedge ref_clk);
    link_live = 1'b0;
    @(negedge ref_clk);
    link_live = 1'b1;
    repeat (3) @(negedge ref_clk);
    `PMSA_CHK("link flag held", 1'b0, link_up_latched)
    i_mac.rd_reg(`PMSA_OFF_STATUS, rd);
    `PMSA_CHK("link drop read", 1'b0, rd[2])
    i_mac.rd_reg(`PMSA_OFF_STATUS, rd);
    `PMSA_CHK("link back read", 1'b1, rd[2])
    @(negedge ref_clk);
    jabber_live = 1'b1;
    @(negedge ref_clk);
    jabber_live = 1'b0;
    repeat (3) @(negedge ref_clk);
    `PMSA_CHK("jabber flag held", 1'b1, jabber_seen)
    i_mac.wr_reg(`PMSA_OFF_STATUS, 16'h0000, 1'b0);
    `PMSA_CHK("jabber after status write", 1'b1, jabber_seen)
    i_mac.rd_reg(`PMSA_OFF_STATUS, rd);
    `PMSA_CHK("jabber read", 1'b1, rd[1])
    i_mac.rd_reg(`PMSA_OFF_STATUS, rd);
    `PMSA_CHK("jabber cleared", 1'b0, rd[1])
    for (int i = 0; i < 4; i++) begin
      w = {i[1], 1'b0, i[0], taf_list[i], `PMSA_SEL_ETHERNET};
      i_mac.wr_rd_reg(`PMSA_OFF_ADVERTISE, w, rd);
      `PMSA_CHK("adv readback", w, rd)
      `PMSA_CHK("adv code word", w, adv_code_word)
    end
    i_mac.wr_reg(`PMSA_OFF_ADVERTISE, 16'hFFFF, 1'b1);
    i_mac.rd_reg(`PMSA_OFF_ADVERTISE, rd);
    `PMSA_CHK("reserved bit", 16'hBFFF, rd)
    `PMSA_CHK("reserved selector", 16'hBFE1, adv_code_word)
    i_mac.wr_reg(`PMSA_OFF_ADVERTISE, 16'h0021, 1'b0);
    converter_mode = 1'b1;
    i_mac.rd_reg(`PMSA_OFF_ADVERTISE, rd);
    `PMSA_CHK("converter read", 16'h0C01, rd)
    `PMSA_CHK("converter word", 16'h0C01, adv_code_word)
    converter_mode = 1'b0;
    i_mac.rd_reg(`PMSA_OFF_ADVERTISE, rd);
    `PMSA_CHK("ability kept", 16'h0021, rd)
    gigabit_adv = 1'b1;
    i_mac.rd_reg(`PMSA_OFF_ADVERTISE, rd);
    `PMSA_CHK("gigabit next page", 16'h8021, rd)
    `PMSA_CHK("gigabit word", 16'h8021, adv_code_word)
    summarize();
  end
endmodule
